/* core/priv_control_exception_return.sv */
// Privileged control unit: vp-disable, hazard barrier, interrupt enable, exception return.
// Assumes issue logic presents one privileged instruction at a time and waits for done.
//
// Notes on behaviour
// - Without cop0 access, vp-disable and interrupt-enable raise coprocessor-unusable.
// - Vp-disable stays unretired until all other targeted processors drain.
// - After siblings disabled, copy old control word to rd, then set flag.
// - Vp-disable with flag already set acts as a no-operation.
// - Paused siblings do not resume on link clear until vp-enable.
// - Waiting siblings ignore interrupts until vp-enable.
// - Siblings are suspended whatever their operating mode.
// - Shift of r0 into r0 by 3 decodes as the hazard barrier.
// - Hazard barrier stalls issue until execution hazards are resolved.
// - Hazard barrier need not clear instruction hazards.
// - Interrupt-enable read and set are indivisible, no exception between.
// - Exception return has no delay slot; next instruction is squashed.
// - Error level selects error pc and clears it, else exception pc.
// - Non-error path with revision, shadow sets, no bootstrap restores shadow set.
// - With compressed ISA_SUPPORT_FIELD, pc takes target with bit 0 cleared, mode flag takes target bit 0.
// - Exception return clears the link reservation flag.
// - Both returns clear all hazards, seen from fetch at target.
// - No-clear return behaves alike but keeps the link reservation flag.
// - Configuration word five shows the no-clear return present bit.
`timescale 1ns/100ps

module priv_control_exception_return #(
  parameter int NUM_VP       = 4,
  parameter int HAZARD_DEPTH = 3
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic                             pready,
  output logic [31:0]                      prdata,
  output logic                             pslverr,
  input  wire priv_ctl_pkg::instr_s        issueInstr,
  input  wire logic [NUM_VP-1:0]           siblingBusy,
  input  wire logic [NUM_VP-1:0]           siblingPaused,
  input  wire logic [NUM_VP-1:0]           siblingWaiting,
  input  wire logic                        vpEnable,
  input  wire logic                        llSet,
  input  wire logic                        hazardPending,
  output logic                             instrDone,
  output logic                             issueStall,
  output logic                             squashNext,
  output logic                             clearHazards,
  output priv_ctl_pkg::result_s            result,
  output priv_ctl_pkg::redirect_s          redirect,
  output logic [NUM_VP-1:0]                siblingFetchOff,
  output logic [NUM_VP-1:0]                siblingIntMask,
  output logic [NUM_VP-1:0]                siblingHoldPause,
  output logic                             linkReservation,
  output logic                             globalIntEnable
);

  // Parameter range the counter and sibling masks can serve
  if (NUM_VP < 2 || HAZARD_DEPTH < 1 || HAZARD_DEPTH > 15) begin : g_badParams
    $error("priv_control_exception_return: unsupported parameters");
  end

  typedef enum logic [1:0] { ST_IDLE, ST_DRAIN, ST_BARRIER } state_e;

  typedef struct packed {
    state_e                   state;
    logic [3:0]               cnt;
    logic [31:0]              status;
    logic [31:0]              exception_pc;
    logic [31:0]              errPc;
    logic [31:0]              shadow;
    logic [31:0]              ctrl;
    logic                     disFlag;
    logic [4:0]               rdHold;
    logic                     llFlag;
    logic                     ready;
    logic [31:0]              rdata;
    logic                     slvErr;
    logic                     done;
    logic                     stall;
    logic                     squash;
    logic                     clrHaz;
    priv_ctl_pkg::result_s    res;
    priv_ctl_pkg::redirect_s  redir;
    logic [NUM_VP-1:0]        fetchOff;
    logic [NUM_VP-1:0]        intMask;
    logic [NUM_VP-1:0]        holdPause;
  } reg_s;

  reg_s st_r;
  reg_s st_nxt;

  // Decode a raw word or explicit op into a unit operation
  function automatic priv_ctl_pkg::op_e decodeOp(input priv_ctl_pkg::instr_s ins);
    if (ins.raw == priv_ctl_pkg::EHB_CODE)
      return priv_ctl_pkg::OP_EHB;
    return ins.op;
  endfunction

  // Old-value write-back, dropped for r0
  function automatic priv_ctl_pkg::result_s mkResult(input logic [4:0] rd,
                                                     input logic [31:0] d);
    priv_ctl_pkg::result_s r;
    r.valid    = 1'b1;
    r.unusable = 1'b0;
    r.wen      = (rd != 5'h00);
    r.rd       = rd;
    r.data     = d;
    return r;
  endfunction

  logic                apbWr;
  logic                apbRd;
  priv_ctl_pkg::op_e   op;
  logic                cu0;
  logic [31:0]         target;
  logic                compressed;
  logic [31:0]         vpWord;

  always_comb begin
    st_nxt      = st_r;
    apbWr       = psel && penable && pwrite && !st_r.ready;
    apbRd       = psel && penable && !pwrite && !st_r.ready;
    op          = issueInstr.valid ? decodeOp(issueInstr) : priv_ctl_pkg::OP_NONE;
    cu0         = st_r.status[priv_ctl_pkg::CU0_POS];
    vpWord      = {31'h0000_0000, st_r.disFlag};
    target      = 32'h0000_0000;
    compressed  = st_r.ctrl[priv_ctl_pkg::C16_POS]
                  || (st_r.ctrl[priv_ctl_pkg::ISAF_LSB +: 2] != 2'h0);

    st_nxt.done     = 1'b0;
    st_nxt.squash   = 1'b0;
    st_nxt.clrHaz   = 1'b0;
    st_nxt.res      = '0;
    st_nxt.redir    = '0;
    st_nxt.ready    = 1'b0;
    st_nxt.slvErr   = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // APB slave, one wait state
    if (apbWr || apbRd) begin
      st_nxt.ready = 1'b1;
      st_nxt.rdata = 32'h0000_0000;
      case (paddr)
        priv_ctl_pkg::OFF_CTRL:   if (apbWr) st_nxt.ctrl = pwdata;
                                  else st_nxt.rdata = st_r.ctrl;
        priv_ctl_pkg::OFF_STATUS: if (apbWr) st_nxt.status = pwdata;
                                  else st_nxt.rdata = st_r.status;
        priv_ctl_pkg::OFF_EPC:    if (apbWr) st_nxt.exception_pc = pwdata;
                                  else st_nxt.rdata = st_r.exception_pc;
        priv_ctl_pkg::OFF_ERRPC:  if (apbWr) st_nxt.errPc = pwdata;
                                  else st_nxt.rdata = st_r.errPc;
        priv_ctl_pkg::OFF_SHADOW: if (apbWr) st_nxt.shadow = pwdata;
                                  else st_nxt.rdata = st_r.shadow;
        priv_ctl_pkg::OFF_VPCTL:  if (!apbWr) st_nxt.rdata = vpWord;
        priv_ctl_pkg::OFF_CFG5:   if (!apbWr) st_nxt.rdata = 32'h0000_0001 << priv_ctl_pkg::LLB_POS;
        priv_ctl_pkg::OFF_STATE:  if (!apbWr) st_nxt.rdata = {30'h0000_0000, st_r.llFlag,
                                                             st_r.stall};
        default:                  st_nxt.slvErr = 1'b1;
      endcase
    end

    // Load-linked sets the reservation
    if (llSet)
      st_nxt.llFlag = 1'b1;

    // Sibling hold released by vp-enable
    if (vpEnable) begin
      st_nxt.disFlag   = 1'b0;
      st_nxt.fetchOff  = '0;
      st_nxt.intMask   = '0;
      st_nxt.holdPause = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Instruction sequencing
    case (st_r.state)
      ST_IDLE: begin
        case (op)
          priv_ctl_pkg::OP_DVP, priv_ctl_pkg::OP_EI: begin
            st_nxt.done = 1'b1;
            if (!cu0) begin
              st_nxt.res.valid    = 1'b1;
              st_nxt.res.unusable = 1'b1;
            end else if (op == priv_ctl_pkg::OP_EI) begin
              // read and set in one cycle
              st_nxt.res = mkResult(issueInstr.rd, st_r.status);
              st_nxt.status[priv_ctl_pkg::IE_POS] = 1'b1;
            end else if (st_r.disFlag) begin
              st_nxt.res = mkResult(issueInstr.rd, vpWord);
            end else begin
              st_nxt.done      = 1'b0;
              st_nxt.stall     = 1'b1;
              st_nxt.rdHold    = issueInstr.rd;
              st_nxt.fetchOff  = '1;
              st_nxt.holdPause = siblingPaused;
              st_nxt.intMask   = siblingWaiting | siblingPaused | '1;
              st_nxt.state     = ST_DRAIN;
            end
          end
          priv_ctl_pkg::OP_EHB: begin
            st_nxt.stall = 1'b1;
            st_nxt.cnt   = 4'(HAZARD_DEPTH);
            st_nxt.state = ST_BARRIER;
          end
          priv_ctl_pkg::OP_EXCEPTION_RETURN_INSTR, priv_ctl_pkg::OP_EXCEPTION_RETURN_KEEP_LINK_INSTR: begin
            st_nxt.done   = 1'b1;
            st_nxt.squash = 1'b1;
            if (st_r.status[priv_ctl_pkg::ERL_POS]) begin
              target = st_r.errPc;
              st_nxt.status[priv_ctl_pkg::ERL_POS] = 1'b0;
            end else begin
              target = st_r.exception_pc;
              st_nxt.status[priv_ctl_pkg::EXL_POS] = 1'b0;
              if (st_r.ctrl[priv_ctl_pkg::REV_LSB +: 3] >= priv_ctl_pkg::MIN_REV
                  && st_r.shadow[priv_ctl_pkg::HSS_LSB +: 4] != 4'h0
                  && !st_r.status[priv_ctl_pkg::BEV_POS])
                st_nxt.shadow[priv_ctl_pkg::CSS_LSB +: 4] =
                  st_r.shadow[priv_ctl_pkg::PSS_LSB +: 4];
            end
            st_nxt.redir.valid = 1'b1;
            if (compressed) begin
              st_nxt.redir.pc      = {target[31:1], 1'b0};
              st_nxt.redir.isa_mode_flag = target[0];
            end else begin
              st_nxt.redir.pc      = target;
              st_nxt.redir.isa_mode_flag = 1'b0;
            end
            if (op == priv_ctl_pkg::OP_EXCEPTION_RETURN_INSTR)
              st_nxt.llFlag = 1'b0;
            st_nxt.clrHaz = 1'b1;
          end
          default: ;
        endcase
      end
      ST_DRAIN: begin
        if (siblingBusy == '0) begin
          // copy old word then set flag
          st_nxt.res     = mkResult(st_r.rdHold, vpWord);
          st_nxt.disFlag = 1'b1;
          st_nxt.done    = 1'b1;
          st_nxt.stall   = 1'b0;
          st_nxt.state   = ST_IDLE;
        end
      end
      ST_BARRIER: begin
        if (st_r.cnt > 4'h1)
          st_nxt.cnt = st_r.cnt - 4'h1;
        else if (!hazardPending) begin
          st_nxt.clrHaz = 1'b1;
          st_nxt.done   = 1'b1;
          st_nxt.stall  = 1'b0;
          st_nxt.state  = ST_IDLE;
        end
      end
      default: st_nxt.state = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register, synchronous reset
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r        <= '0;
      st_r.status <= priv_ctl_pkg::STATUS_RST;
      st_r.ctrl   <= priv_ctl_pkg::CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pready           = st_r.ready;
  assign prdata           = st_r.rdata;
  assign pslverr          = st_r.slvErr;
  assign instrDone        = st_r.done;
  assign issueStall       = st_r.stall;
  assign squashNext       = st_r.squash;
  assign clearHazards     = st_r.clrHaz;
  assign result           = st_r.res;
  assign redirect         = st_r.redir;
  assign siblingFetchOff  = st_r.fetchOff;
  assign siblingIntMask   = st_r.intMask;
  assign siblingHoldPause = st_r.holdPause;
  assign linkReservation  = st_r.llFlag;
  assign globalIntEnable  = st_r.status[priv_ctl_pkg::IE_POS];

  ////////////////////////////////////////////////////////////////////////
  // Sequencing checks
  AST_UNUSABLE: assert property (@(posedge clk) disable iff (rst)
    (st_r.state == ST_IDLE && !cu0
     && (op == priv_ctl_pkg::OP_DVP || op == priv_ctl_pkg::OP_EI))
    |=> (result.valid && result.unusable))
    else $error("coprocessor unusable not raised");

  AST_DRAIN_HOLD: assert property (@(posedge clk) disable iff (rst)
    (st_r.state == ST_DRAIN && siblingBusy != '0) |=> !instrDone)
    else $error("vp-disable retired while siblings busy");

  AST_DIS_NOP: assert property (@(posedge clk) disable iff (rst)
    (st_r.state == ST_IDLE && op == priv_ctl_pkg::OP_DVP && cu0 && st_r.disFlag)
    |=> (instrDone && result.data[0] && !issueStall))
    else $error("vp-disable with flag set did not complete at once");

  AST_BARRIER_STALL: assert property (@(posedge clk) disable iff (rst)
    (st_r.state == ST_BARRIER) |-> issueStall)
    else $error("barrier without issue stall");

  AST_EI_SET: assert property (@(posedge clk) disable iff (rst)
    (st_r.state == ST_IDLE && op == priv_ctl_pkg::OP_EI && cu0)
    |=> (globalIntEnable && result.valid))
    else $error("interrupt enable not set");

  AST_RET_SQUASH: assert property (@(posedge clk) disable iff (rst)
    (st_r.state == ST_IDLE
     && (op == priv_ctl_pkg::OP_EXCEPTION_RETURN_INSTR || op == priv_ctl_pkg::OP_EXCEPTION_RETURN_KEEP_LINK_INSTR))
    |=> (squashNext && clearHazards && redirect.valid))
    else $error("return without squash, hazard clear or redirect");

  AST_LINK_CLEAR: assert property (@(posedge clk) disable iff (rst)
    (st_r.state == ST_IDLE && op == priv_ctl_pkg::OP_EXCEPTION_RETURN_INSTR) |=> !linkReservation)
    else $error("link reservation survived return");
endmodule

/* core/priv_ctl_pkg.sv */
// Package for the privileged control and exception return unit.
// Assumes a single core clock; shared by the unit and its bench.
package priv_ctl_pkg;

  // APB register byte offsets
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_EPC     = 8'h08;
  localparam logic [7:0] OFF_ERRPC   = 8'h0C;
  localparam logic [7:0] OFF_SHADOW  = 8'h10;
  localparam logic [7:0] OFF_VPCTL   = 8'h14;
  localparam logic [7:0] OFF_CFG5    = 8'h18;
  localparam logic [7:0] OFF_STATE   = 8'h1C;

  // Status word field positions
  localparam int IE_POS  = 0;
  localparam int EXL_POS = 1;
  localparam int ERL_POS = 2;
  localparam int BEV_POS = 22;
  localparam int CU0_POS = 28;

  // Shadow set control field positions
  localparam int CSS_LSB = 0;
  localparam int PSS_LSB = 6;
  localparam int HSS_LSB = 26;

  // Control register fields: architecture revision, compressed ISA_SUPPORT_FIELD present, ISA_SUPPORT_FIELD field
  localparam int REV_LSB  = 0;
  localparam int C16_POS  = 4;
  localparam int ISAF_LSB = 8;
  localparam int DIS_POS  = 0;
  localparam int LLB_POS  = 4;

  localparam logic [31:0] STATUS_RST = 32'h0040_0004;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0002;
  localparam logic [2:0]  MIN_REV    = 3'h2;

  // Hazard barrier encoding: shift of r0 into r0 by 3
  localparam logic [31:0] EHB_CODE = 32'h0000_00C0;

  typedef enum logic [2:0] {
    OP_NONE, OP_DVP, OP_EI, OP_EHB, OP_EXCEPTION_RETURN_INSTR, OP_EXCEPTION_RETURN_KEEP_LINK_INSTR
  } op_e;

  typedef struct packed {
    logic        valid;
    op_e         op;
    logic [4:0]  rd;
    logic [31:0] raw;
  } instr_s;

  typedef struct packed {
    logic        valid;
    logic        unusable;
    logic        wen;
    logic [4:0]  rd;
    logic [31:0] data;
  } result_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] pc;
    logic        isa_mode_flag;
  } redirect_s;

endpackage

/* tb/sibling_model.sv */
// Model of the sibling virtual processors: outstanding work drains once fetch is cut.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/100ps
module sibling_model #(
  parameter int NUM_VP = 4
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [NUM_VP-1:0] fetchOff,
  output logic      [NUM_VP-1:0] busy
);
  int cnt [NUM_VP];
  // Uneven drain times per sibling
  always @(posedge clk) begin
    for (int i = 0; i < NUM_VP; i++) begin
      if (rst || !fetchOff[i]) begin
        cnt[i] <= 2 + 3 * i;
      end else if (cnt[i] != 0) begin
        cnt[i] <= cnt[i] - 1;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < NUM_VP; i++) begin
      busy[i] = (cnt[i] != 0);
    end
  end
endmodule

/* tb/tb_priv_control_exception_return.sv */
// Bench for the privileged control unit: APB set-up, instruction issue, checks.
// Assumes the unit answers APB and raises instrDone within bounded cycles.
`timescale 1ns/100ps
module tb_priv_control_exception_return;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic vpEnable = 0, llSet = 0, hazardPending = 0, instrDone, issueStall;
  logic squashNext, clearHazards, linkReservation, globalIntEnable;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rv;
  logic [3:0] siblingBusy, siblingFetchOff, siblingIntMask, siblingHoldPause;
  logic [3:0] siblingPaused = '0, siblingWaiting = '0;
  priv_ctl_pkg::instr_s issueInstr = '0;
  priv_ctl_pkg::result_s result, res;
  priv_ctl_pkg::redirect_s redirect, red;
  logic sq, ch, st, hz, busyAtDone, err;
  int n_mismatch = 0, checked = 0, cyc = 0;
  ////////////////////////////////////////////////////////////////////////////////
  priv_control_exception_return #(.NUM_VP(4), .HAZARD_DEPTH(3)) dut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .issueInstr(issueInstr), .siblingBusy(siblingBusy),
    .siblingPaused(siblingPaused), .siblingWaiting(siblingWaiting),
    .vpEnable(vpEnable), .llSet(llSet), .hazardPending(hazardPending),
    .instrDone(instrDone), .issueStall(issueStall), .squashNext(squashNext),
    .clearHazards(clearHazards), .result(result), .redirect(redirect),
    .siblingFetchOff(siblingFetchOff), .siblingIntMask(siblingIntMask),
    .siblingHoldPause(siblingHoldPause), .linkReservation(linkReservation),
    .globalIntEnable(globalIntEnable));
  sibling_model #(.NUM_VP(4)) sibs (.clk(clk), .rst(rst), .fetchOff(siblingFetchOff),
    .busy(siblingBusy));
  initial begin
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("Compared %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      give_verdict;
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task issue(input priv_ctl_pkg::op_e op, input logic [4:0] rd, input logic [31:0] raw);
    int n;
    res = '0; red = '0; sq = 0; ch = 0; st = 0; n = 0;
    @(posedge clk);
    issueInstr <= '{1'b1, op, rd, raw};
    do begin
      @(posedge clk);
      n++;
      if (n == 1) issueInstr <= '0;
      if (result.valid === 1'b1) res = result;
      if (redirect.valid === 1'b1) red = redirect;
      sq |= (squashNext === 1'b1);
      ch |= (clearHazards === 1'b1);
      st |= (issueStall === 1'b1);
    end while (instrDone !== 1'b1 && n < 300);
    hz = hazardPending;
    busyAtDone = |siblingBusy[3:1];
    issueInstr <= '0;
  endtask
  task pulseLink;
    @(posedge clk) llSet <= 1'b1;
    @(posedge clk) llSet <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, priv_ctl_pkg::OFF_CFG5, '0);
    chk(rv[priv_ctl_pkg::LLB_POS], 1'b1);  // presence bit
    apb(1'b0, 8'h40, '0);
    chk(err, 1'b1);
    // Cop0 access off after reset
    issue(priv_ctl_pkg::OP_DVP, 5'h3, '0);
    chk({res.unusable, res.wen}, 2'b10);  // unusable
    issue(priv_ctl_pkg::OP_EI, 5'h3, '0);
    chk({res.unusable, res.wen}, 2'b10);  // unusable
    apb(1'b1, priv_ctl_pkg::OFF_STATUS, priv_ctl_pkg::STATUS_RST | 32'h1000_0000);
    issue(priv_ctl_pkg::OP_EI, 5'h5, '0);
    chk({res.wen, 26'h0, res.rd}, {1'b1, 26'h0, 5'h5});  // write back
    chk(res.data, priv_ctl_pkg::STATUS_RST | 32'h1000_0000);  // old status
    chk(globalIntEnable, 1'b1);  // enable set
    // Barrier after enable, with a hazard outstanding
    hazardPending <= 1'b1;
    fork
      issue(priv_ctl_pkg::OP_NONE, 5'h0, priv_ctl_pkg::EHB_CODE);
      begin
        repeat (6) @(posedge clk);
        hazardPending <= 1'b0;
      end
    join
    chk({st, hz}, 2'b10);  // stall until clear
    issue(priv_ctl_pkg::OP_EI, 5'h0, '0);
    chk(res.wen, 1'b0);  // no write
    // Disable siblings while they still drain
    siblingPaused <= 4'h2;
    siblingWaiting <= 4'h4;
    issue(priv_ctl_pkg::OP_DVP, 5'h7, '0);
    chk(busyAtDone, 1'b0);  // drained first
    chk(res.data[priv_ctl_pkg::DIS_POS], 1'b0);  // old word
    chk(siblingFetchOff[3:1], 3'h7);  // siblings 1 to 3 suspended
    chk(siblingHoldPause[1], 1'b1);  // pause held
    chk(siblingIntMask[2], 1'b1);  // interrupts ignored
    apb(1'b0, priv_ctl_pkg::OFF_VPCTL, '0);
    chk(rv[priv_ctl_pkg::DIS_POS], 1'b1);  // flag set
    issue(priv_ctl_pkg::OP_DVP, 5'h7, '0);
    chk(res.data[priv_ctl_pkg::DIS_POS], 1'b1);  // nested
    @(posedge clk) vpEnable <= 1'b1;
    @(posedge clk) vpEnable <= 1'b0;
    // Return on the error path
    apb(1'b1, priv_ctl_pkg::OFF_ERRPC, 32'h0000_2000);
    apb(1'b1, priv_ctl_pkg::OFF_EPC, 32'h0000_1001);
    pulseLink;
    issue(priv_ctl_pkg::OP_EXCEPTION_RETURN_INSTR, 5'h0, '0);  // clearing return
    chk(red.pc, 32'h0000_2000);  // error pc
    chk({sq, ch, linkReservation}, 3'b110);
    apb(1'b0, priv_ctl_pkg::OFF_STATUS, '0);
    chk(rv[priv_ctl_pkg::ERL_POS], 1'b0);  // level cleared
    // Keep-link return, exception path, compressed ISA_SUPPORT_FIELD
    apb(1'b1, priv_ctl_pkg::OFF_STATUS, 32'h1000_0002);
    apb(1'b1, priv_ctl_pkg::OFF_SHADOW, 32'h0400_00C0);
    apb(1'b1, priv_ctl_pkg::OFF_CTRL, priv_ctl_pkg::CTRL_RST | 32'h10);
    pulseLink;
    issue(priv_ctl_pkg::OP_EXCEPTION_RETURN_KEEP_LINK_INSTR, 5'h0, '0);
    chk(red.pc, 32'h0000_1000);
    chk(red.isa_mode_flag, 1'b1);
    chk({sq, ch, linkReservation}, 3'b111);
    apb(1'b0, priv_ctl_pkg::OFF_SHADOW, '0);
    chk(rv[3:0], 4'h3);  // shadow restored
    apb(1'b0, priv_ctl_pkg::OFF_STATUS, '0);
    chk(rv[priv_ctl_pkg::EXL_POS], 1'b0);  // level cleared
    give_verdict;
  end
endmodule
